/* design/rflb_pkg.sv */
package rflb_pkg;
	// Register addresses on the host register port
	localparam logic [7:0] ADDR_CONVERSION_RESULT = 8'h19;
	localparam logic [7:0] ADDR_RX_LEN_HIGH = 8'h1A;
	localparam logic [7:0] ADDR_RX_LEN_LOW = 8'h1B;
	localparam logic [7:0] ADDR_BUFFER_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_SEND_LEN_UPPER = 8'h1D;
	localparam logic [7:0] ADDR_SEND_LEN_LOWER = 8'h1E;
	localparam logic [7:0] ADDR_BUFFER_DATA = 8'h1F;
	// Direct command codes handled here
	localparam logic [7:0] CMD_TRIGGER_ADC = 8'h87;
	localparam logic [7:0] CMD_RESET_BUFFER = 8'h8F;
	// Bit positions
	localparam int RXH_SKIP_CHECK_BIT = 7;
	localparam int RXH_RAW_OPTION_BIT = 6;
	localparam int STAT_HIGH_BIT = 7;
	localparam int STAT_LOW_BIT = 6;
	localparam int STAT_OVF_BIT = 5;
	localparam int SEND_PARTIAL_FLAG_BIT = 0;
	// Buffer shape and thresholds
	localparam int BUF_DEPTH = 24;
	localparam int HIGH_LEVEL = 18;
	localparam int LOW_LEVEL = 6;
	localparam int START_BYTES = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Measurement source codes
	localparam logic [2:0] MSEL_MIXER_A = 3'h1;
	localparam logic [2:0] MSEL_MIXER_B = 3'h2;
	localparam logic [2:0] MSEL_PIN = 3'h3;
	// Conversion timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADC_VALID_NS = 20000;
	localparam int ADC_VALID_CYCLES = ADC_VALID_NS / CLK_PERIOD_NS;
	localparam int ADC_CONV_CYCLES = 16;
endpackage

/* design/rflb_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
// Circular byte buffer, one port in, one port out, clearable.
module rflb_buffer
	import rflb_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] pop_data,
	output logic [4:0] fill,
	output logic overflow
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [4:0] fill_r, fill_nxt;
	logic ovf_r, ovf_nxt;
	logic do_push, do_pop;

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Pointer and level bookkeeping; full pushes are dropped unless a pop frees a slot in the same cycle
	always_comb
	begin
		do_pop = pop && (fill_r != 5'h00);
		do_push = push && (fill_r != 5'(DEPTH) || do_pop);
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		fill_nxt = fill_r;
		ovf_nxt = ovf_r;
		if (clear)
		begin
			wr_nxt = '0; // R18
			rd_nxt = '0;
			fill_nxt = 5'h00;
			ovf_nxt = 1'b0; // R21
		end
		else
		begin
			if (do_push)
				wr_nxt = wrap_inc(wr_r); // R16
			if (do_pop)
				rd_nxt = wrap_inc(rd_r); // R20
			if (push && !do_push)
				ovf_nxt = 1'b1; // R8
			if (do_push && !do_pop)
				fill_nxt = fill_r + 5'h01;
			else if (do_pop && !do_push)
				fill_nxt = fill_r - 5'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_r <= '0;
			rd_r <= '0;
			fill_r <= 5'h00;
			ovf_r <= 1'b0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			fill_r <= fill_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	// Storage has no reset, it only holds data
	always_ff @(posedge sys_clk)
	begin
		if (do_push && !clear)
			mem[wr_r] <= push_data;
	end

	assign pop_data = mem[rd_r];
	assign fill = fill_r;
	assign overflow = ovf_r;
endmodule
`default_nettype wire

/* design/rflb_adc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Converter sequencer: pick the source, sample, then publish the result.
module rflb_adc_ctrl
	import rflb_pkg::*;
#(
	parameter int CONV_CYCLES = ADC_CONV_CYCLES
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic trigger,
	input wire logic [2:0] msel,
	input wire logic [7:0] mixer_a_level,
	input wire logic [7:0] mixer_b_level,
	input wire logic [7:0] pin_level,
	output logic [7:0] result,
	output logic busy
);
	logic [7:0] res_r, res_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [7:0] src;

	// Source selection follows the measurement field
	always_comb
	begin
		case (msel) // R2
			MSEL_MIXER_A: src = mixer_a_level;
			MSEL_MIXER_B: src = mixer_b_level;
			MSEL_PIN: src = pin_level;
			default: src = 8'h00;
		endcase
	end

	// Count down a fixed conversion time, well inside the valid limit
	always_comb
	begin
		res_nxt = res_r;
		cnt_nxt = cnt_r;
		if (trigger)
			cnt_nxt = 16'(CONV_CYCLES);
		else if (cnt_r != 16'h0000)
		begin
			cnt_nxt = cnt_r - 16'h0001;
			if (cnt_r == 16'h0001)
				res_nxt = src; // R1
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			res_r <= 8'h00;
			cnt_r <= 16'h0000;
		end
		else
		begin
			res_r <= res_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign result = res_r;
	assign busy = (cnt_r != 16'h0000);
endmodule
`default_nettype wire

/* design/rflb_top.sv */
// Summary of operation
// R1 - ADC result valid within 20 us
// R2 - ADC source from measurement select field
// R3 - Skip-check bit lasts one reception
// R4 - Raw option: all bytes, remapped interrupts
// R5 - 10-bit receive length, cleared at end
// R6 - High flag at 18 bytes in RX
// R7 - Low flag at 6 bytes in TX
// R8 - Overflow flag on write beyond capacity
// R9 - Status low bits show unread bytes
// R10 - Upper send length, cleared at TX end
// R11 - Lower send length nibble, bits, flag
// R12 - Partial bit count ignored without flag
// R13 - Lower send length write-only for TX
// R14 - RX bit count read-only, success update
// R15 - Partial bits sit at LSB end
// R16 - 24-byte circular buffer, one address
// R17 - Status and send length reset low-enable
// R18 - Reset command clears pointers and flags
// R19 - Start sending at third byte loaded
// R20 - Data port write appends, read pops
// R21 - Overflow sticky until buffer reset
`timescale 1ns/1ns
`default_nettype none
module rflb_top
	import rflb_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic enable,
	// Host register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Direct command strobe
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [2:0] msel,
	// Converter sources
	input wire logic [7:0] mixer_a_level,
	input wire logic [7:0] mixer_b_level,
	input wire logic [7:0] pin_level,
	// Framing side
	input wire logic tx_active,
	input wire logic tx_eof,
	input wire logic rx_active,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_is_crc,
	input wire logic rx_end,
	input wire logic rx_ok,
	input wire logic [2:0] rx_last_bits,
	input wire logic tx_byte_req,
	output logic [7:0] tx_byte,
	output logic tx_start,
	output logic [11:0] tx_byte_count,
	output logic [2:0] tx_partial_bits,
	output logic tx_partial,
	output logic rx_check_crc,
	output logic rx_raw_mode,
	output logic irq_header_sel,
	output logic third_error_interrupt_sel,
	output logic buffer_clear
);
	logic [7:0] rxh_r, rxh_nxt, rxl_r, rxl_nxt;
	logic [7:0] su_r, su_nxt, sl_r, sl_nxt;
	logic [2:0] rxbits_r, rxbits_nxt;
	logic [11:0] loaded_r, loaded_nxt;
	logic started_r, started_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic en_s1_r, en_s2_r;
	logic clr, host_push, host_pop, push, pop;
	logic [7:0] push_data, pop_data, status;
	logic [4:0] fill;
	logic overflow, adc_busy;
	logic [7:0] adc_result;
	logic [11:0] total;

	// All checks sample on the one clock and rest while in reset
	default clocking cb_chk @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// Enable pin passes two flops before use
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end
		else
		begin
			en_s1_r <= enable;
			en_s2_r <= en_s1_r;
		end
	end

	// Buffer clear: command or enable low
	assign clr = !en_s2_r ||
		(cmd_valid && cmd_code == CMD_RESET_BUFFER); // R18
	assign buffer_clear = clr;
	assign host_push = reg_wr && reg_addr == ADDR_BUFFER_DATA; // R20
	assign host_pop = reg_rd && reg_addr == ADDR_BUFFER_DATA;
	// Raw option lets CRC bytes through, else they are dropped
	assign push = host_push || (rx_byte_valid &&
		(!rx_byte_is_crc || rxh_r[RXH_RAW_OPTION_BIT])); // R4
	assign push_data = host_push ? reg_wdata : rx_byte;
	assign pop = host_pop || tx_byte_req;

	rflb_buffer #(
		.DEPTH(DEPTH)
	) u_buffer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clear(clr),
		.push(push),
		.push_data(push_data),
		.pop(pop),
		.pop_data(pop_data),
		.fill(fill),
		.overflow(overflow)
	);

	rflb_adc_ctrl u_adc (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.trigger(cmd_valid && cmd_code == CMD_TRIGGER_ADC),
		.msel(msel),
		.mixer_a_level(mixer_a_level),
		.mixer_b_level(mixer_b_level),
		.pin_level(pin_level),
		.result(adc_result),
		.busy(adc_busy)
	);

	// Status: level flags qualified by direction, overflow, fill count
	always_comb
	begin
		status = {3'b000, fill}; // R9
		status[STAT_HIGH_BIT] = rx_active && fill >= 5'(HIGH_LEVEL); // R6
		status[STAT_LOW_BIT] = tx_active && fill <= 5'(LOW_LEVEL); // R7
		status[STAT_OVF_BIT] = overflow; // R8
	end

	assign total = {su_r, sl_r[7:4]};

	// Length registers, skip-check one-shot and transmit start logic
	always_comb
	begin
		rxh_nxt = rxh_r;
		rxl_nxt = rxl_r;
		su_nxt = su_r;
		sl_nxt = sl_r;
		rxbits_nxt = rxbits_r;
		loaded_nxt = loaded_r;
		started_nxt = started_r;
		if (reg_wr && reg_addr == ADDR_RX_LEN_HIGH)
			rxh_nxt = reg_wdata;
		if (reg_wr && reg_addr == ADDR_RX_LEN_LOW)
			rxl_nxt = reg_wdata;
		if (reg_wr && reg_addr == ADDR_SEND_LEN_UPPER)
			su_nxt = reg_wdata; // R10
		if (reg_wr && reg_addr == ADDR_SEND_LEN_LOWER)
		begin
			sl_nxt = reg_wdata; // R11
			loaded_nxt = 12'h000; // R19
			started_nxt = 1'b0;
		end
		if (host_push && loaded_r != 12'hFFF)
			loaded_nxt = loaded_r + 12'h001;
		if (rx_end)
		begin
			rxh_nxt = RESET_BYTE; // R5 R3
			rxl_nxt = RESET_BYTE;
			if (rx_ok)
				rxbits_nxt = rx_last_bits; // R14 R15
		end
		if (tx_eof)
		begin
			su_nxt = RESET_BYTE; // R10
			started_nxt = 1'b0;
			loaded_nxt = 12'h000;
		end
		if (tx_start)
			started_nxt = 1'b1;
		if (clr)
		begin
			loaded_nxt = 12'h000;
			started_nxt = 1'b0;
		end
		if (!en_s2_r)
		begin
			rxh_nxt = RESET_BYTE; // R17 R5
			rxl_nxt = RESET_BYTE;
			su_nxt = RESET_BYTE;
			sl_nxt = RESET_BYTE;
			rxbits_nxt = 3'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxh_r <= RESET_BYTE;
			rxl_r <= RESET_BYTE;
			su_r <= RESET_BYTE;
			sl_r <= RESET_BYTE;
			rxbits_r <= 3'h0;
			loaded_r <= 12'h000;
			started_r <= 1'b0;
		end
		else
		begin
			rxh_r <= rxh_nxt;
			rxl_r <= rxl_nxt;
			su_r <= su_nxt;
			sl_r <= sl_nxt;
			rxbits_r <= rxbits_nxt;
			loaded_r <= loaded_nxt;
			started_r <= started_nxt;
		end
	end

	// Start once three bytes loaded, or all of a shorter message
	always_comb
	begin
		tx_start = 1'b0;
		// A lone partial byte still makes a message worth sending
		if (!started_r && en_s2_r &&
			(total != 12'h000 || sl_r[SEND_PARTIAL_FLAG_BIT]))
			if (loaded_r >= 12'(START_BYTES) ||
				loaded_r >= total + {11'h000, sl_r[SEND_PARTIAL_FLAG_BIT]})
				tx_start = 1'b1; // R19
	end

	assign tx_byte = pop_data;
	assign tx_byte_count = total;
	assign tx_partial = sl_r[SEND_PARTIAL_FLAG_BIT];
	// Bit count only counts with the flag set
	assign tx_partial_bits = sl_r[SEND_PARTIAL_FLAG_BIT] ?
		sl_r[3:1] : 3'h0; // R12
	assign rx_check_crc = !rxh_r[RXH_SKIP_CHECK_BIT]; // R3
	assign rx_raw_mode = rxh_r[RXH_RAW_OPTION_BIT]; // R4
	assign irq_header_sel = !rxh_r[RXH_RAW_OPTION_BIT]; // R4
	assign third_error_interrupt_sel = !rxh_r[RXH_RAW_OPTION_BIT];

	// Read mux, registered for one-cycle-later data
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_CONVERSION_RESULT: rdata_nxt = adc_result;
				ADDR_RX_LEN_HIGH: rdata_nxt = rxh_r;
				ADDR_RX_LEN_LOW: rdata_nxt = rxl_r;
				ADDR_BUFFER_STATUS: rdata_nxt = status;
				ADDR_SEND_LEN_UPPER: rdata_nxt = su_r;
				// Written send value never reads back
				ADDR_SEND_LEN_LOWER: rdata_nxt = {4'h0, rxbits_r, 1'b0}; // R13 R14
				ADDR_BUFFER_DATA: rdata_nxt = fill != 5'h00 ? pop_data : 8'h00;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;

	// Checks
	// One host read strobe, qualified by its address
	sequence s_status_rd;
		reg_rd && reg_addr == ADDR_BUFFER_STATUS;
	endsequence
	sequence s_data_rd;
		reg_rd && reg_addr == ADDR_BUFFER_DATA;
	endsequence

	a_adc_done: assert property ($fell(adc_busy) |-> // R1
		$past(adc_busy, ADC_CONV_CYCLES))
		else $error("conversion time wrong");
	// Flags are judged on what the host reads back, not on the mux
	a_high_flag: assert property (s_status_rd ##0 // R6
		(rx_active && fill >= 5'(HIGH_LEVEL)) |=> reg_rdata[STAT_HIGH_BIT])
		else $error("high flag missing");
	a_high_quiet: assert property (s_status_rd ##0 // R6
		(fill < 5'(HIGH_LEVEL)) |=> !reg_rdata[STAT_HIGH_BIT])
		else $error("high flag early");
	a_low_flag: assert property (s_status_rd ##0 // R7
		(tx_active && fill <= 5'(LOW_LEVEL)) |=> reg_rdata[STAT_LOW_BIT])
		else $error("low flag missing");
	a_count_read: assert property (s_status_rd |=> // R9
		reg_rdata[4:0] == $past(fill))
		else $error("byte count misreported");
	a_ovf_sticky: assert property ((overflow && !clr) |=> overflow) // R21
		else $error("overflow dropped");
	a_ovf_set: assert property ((push && !pop && fill == 5'(DEPTH) // R8
		&& !clr) |=> overflow)
		else $error("overflow not set");
	a_fill_cap: assert property (fill <= 5'(DEPTH)) // R16
		else $error("fill above depth");
	a_tx_eof_clr: assert property (tx_eof |=> su_r == RESET_BYTE) // R10
		else $error("upper length kept");
	a_rx_end_clr: assert property (rx_end |=> // R5
		(rxh_r == RESET_BYTE && rxl_r == RESET_BYTE))
		else $error("rx length kept");
	a_clear_fill: assert property (clr |=> fill == 5'h00) // R18
		else $error("clear failed");
	a_read_hide: assert property ((reg_rd && // R13
		reg_addr == ADDR_SEND_LEN_LOWER) |=> reg_rdata[7:4] == 4'h0)
		else $error("send length readable");
	a_empty_read: assert property (s_data_rd ##0 (fill == 5'h00) |=> // R20
		reg_rdata == 8'h00)
		else $error("empty read not zero");
	a_pop_step: assert property (s_data_rd ##0 (fill != 5'h00 && !push && // R20
		!clr) |=> fill == $past(fill) - 5'h01)
		else $error("read did not pop");
	a_start_once: assert property (tx_start |=> !tx_start) // R19
		else $error("start repeated");
	// A failed reception leaves the last good bit count alone
	a_rx_bits_hold: assert property ((rx_end && !rx_ok && en_s2_r) |=> // R14
		$stable(rxbits_r))
		else $error("bit count moved");
	// Enable low wipes lengths and buffer one edge later
	a_enable_low: assert property (!en_s2_r |=> (su_r == RESET_BYTE && // R17
		sl_r == RESET_BYTE && fill == 5'h00 && !overflow))
		else $error("enable low kept state");
endmodule
`default_nettype wire

/* test/rflb_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host side of the register port: one-cycle strobes, never overlapping
module rflb_host
(
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// Idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One write cycle, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Step off the edge so callers see the settled registers
		#1;
	end
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	end
	endtask
endmodule
`default_nettype wire

/* test/reader_fifo_length_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module reader_fifo_length_regs_test;
	import rflb_pkg::*;
	logic sys_clk, reset_n, enable, reg_wr, reg_rd, cmd_valid, tx_active;
	logic tx_eof, rx_active, rx_byte_valid, rx_byte_is_crc, rx_end, rx_ok;
	logic tx_byte_req, tx_start, tx_partial, rx_check_crc, rx_raw_mode;
	logic irq_header_sel, third_error_interrupt_sel, buffer_clear;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code, rx_byte, tx_byte, d;
	logic [7:0] mixer_a_level, mixer_b_level, pin_level;
	logic [2:0] msel, rx_last_bits, tx_partial_bits;
	logic [11:0] tx_byte_count;
	logic [31:0] seed;
	logic [7:0] q[$];
	int err_count, checked, i, base;
	int starts = 0;
	// Strobe selectors for pulse
	localparam int S_CMD = 0;
	localparam int S_RXB = 1;
	localparam int S_END = 2;
	localparam int S_REQ = 3;
	localparam int S_EOF = 4;

	rflb_top dut_u (.sys_clk, .reset_n, .enable, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_code, .msel,
		.mixer_a_level, .mixer_b_level, .pin_level, .tx_active, .tx_eof,
		.rx_active, .rx_byte_valid, .rx_byte, .rx_byte_is_crc, .rx_end,
		.rx_ok, .rx_last_bits, .tx_byte_req, .tx_byte, .tx_start,
		.tx_byte_count, .tx_partial_bits, .tx_partial, .rx_check_crc,
		.rx_raw_mode, .irq_header_sel, .third_error_interrupt_sel, .buffer_clear);
	rflb_host host_u (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);

	// 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Start pulses are combinational, so count them at the edge
	always @(posedge sys_clk)
		if (tx_start === 1'b1)
			starts <= starts + 1;

	// Xorshift source, fixed seed for repeatable runs
	function automatic logic [7:0] rb();
	begin
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	end
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
	begin
		host_u.rd(a, d);
		check(d, exp);
	end
	endtask

	// Data port write; the model drops what a full buffer refuses
	task automatic dwr(input logic [7:0] v);
	begin
		host_u.wr(ADDR_BUFFER_DATA, v);
		if (q.size() < BUF_DEPTH)
			q.push_back(v);
	end
	endtask

	// One-cycle strobe: raised after one edge, dropped after the next
	task automatic pulse(input int k);
	begin
		repeat (2)
		begin
			@(posedge sys_clk);
			case (k)
				S_CMD: cmd_valid <= ~cmd_valid;
				S_RXB: rx_byte_valid <= ~rx_byte_valid;
				S_END: rx_end <= ~rx_end;
				S_REQ: tx_byte_req <= ~tx_byte_req;
				default: tx_eof <= ~tx_eof;
			endcase
		end
	end
	endtask

	task automatic stop_test;
	begin
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	// Whole run needs well under 10k cycles
	initial
	begin
		#200000;
		err_count++;
		stop_test;
	end

	initial
	begin
		{reset_n, cmd_valid, tx_active, tx_eof, rx_active, rx_byte_valid} = 0;
		{rx_byte_is_crc, rx_end, tx_byte_req, cmd_code, rx_byte, msel} = 0;
		{mixer_a_level, mixer_b_level, pin_level, rx_last_bits} = 0;
		{err_count, checked} = 0;
		enable = 1'b1;
		rx_ok = 1'b1;
		seed = 32'h7F7A56FD;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdc(8'h05, 8'h00);
		for (i = 26; i < 31; i++)
			rdc(i[7:0], 8'h00);
		// Every source code, read at the 20 us deadline
		for (i = 1; i < 4; i++)
		begin
			mixer_a_level <= rb();
			mixer_b_level <= rb();
			pin_level <= rb();
			msel <= i[2:0];
			cmd_code <= CMD_TRIGGER_ADC;
			pulse(S_CMD);
			repeat (ADC_VALID_CYCLES - 2) @(posedge sys_clk);
			rdc(ADDR_CONVERSION_RESULT, i == 1 ? mixer_a_level :
				i == 2 ? mixer_b_level : pin_level);
		end
		for (i = 0; i < 25; i++)
			dwr(rb());
		rdc(ADDR_BUFFER_STATUS, 8'h38);
		for (i = 0; i < 24; i++)
			rdc(ADDR_BUFFER_DATA, q.pop_front());
		rdc(ADDR_BUFFER_STATUS, 8'h20);
		rdc(ADDR_BUFFER_DATA, 8'h00);
		cmd_code <= CMD_RESET_BUFFER;
		pulse(S_CMD);
		rdc(ADDR_BUFFER_STATUS, 8'h00);
		// Reception with one-shot skip and raw option
		host_u.wr(ADDR_RX_LEN_HIGH, 8'hC3);
		host_u.wr(ADDR_RX_LEN_LOW, 8'h45);
		check({rx_check_crc, rx_raw_mode, irq_header_sel, third_error_interrupt_sel},
			4'b0100);
		rx_active <= 1'b1;
		// Last two bytes are checksum bytes, kept by the raw option
		for (i = 0; i < HIGH_LEVEL; i++)
		begin
			rx_byte <= rb();
			rx_byte_is_crc <= (i >= HIGH_LEVEL - 2);
			q.push_back(seed[7:0]);
			pulse(S_RXB);
		end
		rx_byte_is_crc <= 1'b0;
		rdc(ADDR_BUFFER_STATUS, 8'h92);
		for (i = 0; i < HIGH_LEVEL; i++)
			rdc(ADDR_BUFFER_DATA, q.pop_front());
		rx_last_bits <= 3'h5;
		pulse(S_END);
		rx_active <= 1'b0;
		rdc(ADDR_RX_LEN_HIGH, 8'h00);
		rdc(ADDR_RX_LEN_LOW, 8'h00);
		check({rx_check_crc, rx_raw_mode, irq_header_sel, third_error_interrupt_sel},
			4'b1011);
		// Lengths first, then data: the host side of the start rule
		tx_active <= 1'b1;
		host_u.wr(ADDR_SEND_LEN_UPPER, 8'h01);
		host_u.wr(ADDR_SEND_LEN_LOWER, 8'h3B);
		check(tx_byte_count, 12'h013);
		check({tx_partial_bits, tx_partial}, 4'hB);
		rdc(ADDR_SEND_LEN_LOWER, 8'h0A);
		// A failed reception must not touch the bit count
		rx_ok <= 1'b0;
		rx_last_bits <= 3'h2;
		pulse(S_END);
		rdc(ADDR_SEND_LEN_LOWER, 8'h0A);
		rx_ok <= 1'b1;
		base = starts;
		for (i = 0; i < 7; i++)
		begin
			dwr(rb());
			if (i == 1)
				check(starts - base, 0);
		end
		check(starts - base, 1);
		rdc(ADDR_BUFFER_STATUS, 8'h07);
		@(posedge sys_clk);
		check(tx_byte, q.pop_front());
		pulse(S_REQ);
		rdc(ADDR_BUFFER_STATUS, 8'h46);
		pulse(S_EOF);
		tx_active <= 1'b0;
		rdc(ADDR_SEND_LEN_UPPER, 8'h00);
		// Enable low wipes status and lengths
		host_u.wr(ADDR_SEND_LEN_UPPER, 8'h22);
		enable <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		check(buffer_clear, 1'b1);
		enable <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rdc(ADDR_BUFFER_STATUS, 8'h00);
		rdc(ADDR_SEND_LEN_UPPER, 8'h00);
		check(buffer_clear, 1'b0);
		// Two-byte message starts on its second byte
		host_u.wr(ADDR_SEND_LEN_LOWER, 8'h20);
		base = starts;
		dwr(rb());
		check(starts - base, 0);
		dwr(rb());
		@(posedge sys_clk);
		#1;
		check(starts - base, 1);
		stop_test;
	end
endmodule
`default_nettype wire
